// ===== rtl/sfsp_consts.svh
// constants of the serial flash status and protection block
`ifndef SFSP_CONSTS_SVH
`define SFSP_CONSTS_SVH
`define SFSP_BIT_BUSY      0
`define SFSP_BIT_WEL       1
`define SFSP_BIT_BP0       2
`define SFSP_BIT_BP1       3
`define SFSP_BIT_BP2       4
`define SFSP_BIT_SWD       7
`define SFSP_STATUS_RESET  8'h00
`define SFSP_OP_WRITE_ENABLE_CMD_CODE  8'h06
`define SFSP_OP_WRITE_DISABLE_CMD_CODE  8'h04
`define SFSP_OP_WRST_CODE  8'h01
`define SFSP_OP_RDST_CODE  8'h05
`define SFSP_OP_PROG_CODE  8'h02
`define SFSP_OP_SERA_CODE  8'hD7
`define SFSP_OP_SERB_CODE  8'h20
`define SFSP_OP_BERA_CODE  8'hD8
`define SFSP_OP_CERA_CODE  8'hC7
`define SFSP_OP_CERB_CODE  8'h60
`define SFSP_TOP_2M        18'h3FFFF
`define SFSP_TOP_1M        18'h1FFFF
`define SFSP_TOP_512K      18'h0FFFF
`define SFSP_Q_2M          18'h30000
`define SFSP_H_2M          18'h20000
`define SFSP_Q_1M          18'h18000
`define SFSP_H_1M          18'h10000
`define SFSP_WRST_TIME_NS  1000
`define SFSP_CLK_NS        10
`define SFSP_WRST_CYC      ((`SFSP_WRST_TIME_NS + `SFSP_CLK_NS - 1) / `SFSP_CLK_NS)
`endif

// ===== rtl/sfsp_pkg.sv
// types of the serial flash status and protection block
package sfsp_pkg;
  typedef enum logic [1:0] {
    SFSP_SZ_512K = 2'h0,
    SFSP_SZ_1M   = 2'h1,
    SFSP_SZ_2M   = 2'h2
  } sfsp_size_e;
  typedef enum logic [3:0] {
    SFSP_IDLE = 4'h1,
    SFSP_CODE = 4'h2,
    SFSP_TAIL = 4'h4,
    SFSP_DONE = 4'h8
  } sfsp_state_e;
  typedef logic [17:0] sfsp_addr_t;
endpackage

// ===== rtl/sfsp_guard_if.sv
// carrier between the main block and its region check
`timescale 1ns/100ps
interface sfsp_guard_if;
  logic [1:0]  bp_low;
  logic [17:0] addr;
  logic        hit;
  modport owner (output bp_low, output addr, input hit);
  modport check (input bp_low, input addr, output hit);
endinterface

// ===== rtl/sfsp_region_check.sv
// protected region decode for one address
`timescale 1ns/100ps
`include "sfsp_consts.svh"
module sfsp_region_check #(
  parameter logic [1:0] SIZE = 2'h2
) (
  sfsp_guard_if.check g
);
  import sfsp_pkg::*;
  wire [17:0] top_w  = (SIZE == 2'h2) ? `SFSP_TOP_2M : (SIZE == 2'h1) ? `SFSP_TOP_1M : `SFSP_TOP_512K;
  wire [17:0] q_w    = (SIZE == 2'h2) ? `SFSP_Q_2M : `SFSP_Q_1M;
  wire [17:0] h_w    = (SIZE == 2'h2) ? `SFSP_H_2M : `SFSP_H_1M;
  wire        small_w = (SIZE == 2'h0);
  wire        in_w   = (g.addr <= top_w);
  // small part guards only on both bits set
  assign g.hit = in_w & ((g.bp_low == 2'h3) |
                 (!small_w & (g.bp_low == 2'h1) & (g.addr >= q_w)) |
                 (!small_w & (g.bp_low == 2'h2) & (g.addr >= h_w)));
  initial begin
    if (SIZE > 2'h2) $error("unsupported size");
  end
endmodule // sfsp_region_check

// ===== rtl/sfsp_status_protect.sv
// status register, write enable latch and block protection of a serial flash
`timescale 1ns/100ps
`include "sfsp_consts.svh"
module sfsp_status_protect #(
  parameter logic [1:0] SIZE     = 2'h2,
  parameter int         WRST_CYC = `SFSP_WRST_CYC
) (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  // serial link pins
  input  wire logic       spi_sck,
  input  wire logic       spi_cs_n,
  input  wire logic       spi_si,
  input  wire logic       wp_n,
  output logic            spi_so,
  output logic            spi_so_oe_n,
  // array engine handshake
  output logic            prog_start,
  output logic            erase_start,
  output logic            full_erase_start,
  output logic [7:0]      op_code,
  output sfsp_pkg::sfsp_addr_t op_addr,
  input  wire logic       array_busy,
  // status view
  output logic [7:0]      status_byte
);
  import sfsp_pkg::*;

  // pin synchronisers
  logic [1:0] sck_s_reg, cs_s_reg, si_s_reg, wp_s_reg;
  logic       sck_d_reg;
  always_ff @(posedge mclk) begin
    sck_s_reg <= {sck_s_reg[0], spi_sck};
    cs_s_reg  <= {cs_s_reg[0], spi_cs_n};
    si_s_reg  <= {si_s_reg[0], spi_si};
    wp_s_reg  <= {wp_s_reg[0], wp_n};
    sck_d_reg <= sck_s_reg[1];
  end
  wire sel_w  = !cs_s_reg[1];
  wire rise_w = sel_w & sck_s_reg[1] & !sck_d_reg;
  wire fall_w = sel_w & !sck_s_reg[1] & sck_d_reg;
  wire wp_hi_w = wp_s_reg[1];

  // frame shifting
  sfsp_state_e state_reg, state_next;
  logic [2:0]  bit_cnt_reg;
  logic [7:0]  shift_reg;
  logic [7:0]  code_reg;
  logic [2:0]  byte_cnt_reg;
  logic [23:0] addr_sh_reg;
  logic [7:0]  data_reg;
  logic        cs_d_reg;
  always_ff @(posedge mclk) begin
    cs_d_reg <= sel_w;
  end
  wire frame_end_w = cs_d_reg & !sel_w;
  wire [7:0] shift_next = {shift_reg[6:0], si_s_reg[1]};
  wire byte_done_w = rise_w & (bit_cnt_reg == 3'h7);
  wire whole_w = (bit_cnt_reg == 3'h0);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      SFSP_IDLE: if (sel_w) state_next = SFSP_CODE;
      SFSP_CODE: if (frame_end_w) state_next = SFSP_IDLE;
                 else if (byte_done_w) state_next = SFSP_TAIL;
      SFSP_TAIL: if (frame_end_w) state_next = SFSP_DONE;
      SFSP_DONE: state_next = SFSP_IDLE;
      default:   state_next = SFSP_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_reg    <= SFSP_IDLE;
      bit_cnt_reg  <= 3'h0;
      shift_reg    <= 8'h00;
      code_reg     <= 8'h00;
      byte_cnt_reg <= 3'h0;
      addr_sh_reg  <= 24'h000000;
      data_reg     <= 8'h00;
    end else begin
      state_reg <= state_next;
      if (state_reg == SFSP_IDLE) begin
        bit_cnt_reg  <= 3'h0;
        byte_cnt_reg <= 3'h0;
      end else if (rise_w) begin
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
        shift_reg   <= shift_next;
      end
      if (byte_done_w) begin
        if (state_reg == SFSP_CODE) code_reg <= shift_next;
        else begin
          if (byte_cnt_reg < 3'h3) addr_sh_reg <= {addr_sh_reg[15:0], shift_next};
          if (byte_cnt_reg == 3'h0) data_reg <= shift_next;
          if (byte_cnt_reg != 3'h7) byte_cnt_reg <= byte_cnt_reg + 3'h1;
        end
      end
    end
  end

  // status bits
  logic       busy_reg, wel_reg, swd_reg;
  logic [2:0] bp_reg;
  logic       wrst_busy_reg;
  logic [$clog2(WRST_CYC+1)-1:0] wrst_cnt_reg;
  logic       arr_d_reg;
  // busy must bridge the gap before the engine raises its own busy
  logic       arr_pend_reg;

  wire end_ok_w  = (state_reg == SFSP_DONE) & whole_w;
  wire is_write_enable_cmd_w = end_ok_w & (code_reg == `SFSP_OP_WRITE_ENABLE_CMD_CODE) & (byte_cnt_reg == 3'h0);
  wire is_write_disable_cmd_w = end_ok_w & (code_reg == `SFSP_OP_WRITE_DISABLE_CMD_CODE) & (byte_cnt_reg == 3'h0);
  wire is_wrst_w = end_ok_w & (code_reg == `SFSP_OP_WRST_CODE) & (byte_cnt_reg == 3'h1);
  wire is_prog_w = end_ok_w & (code_reg == `SFSP_OP_PROG_CODE) & (byte_cnt_reg >= 3'h4);
  wire is_era_w  = end_ok_w & (byte_cnt_reg == 3'h3) & ((code_reg == `SFSP_OP_SERA_CODE) |
                   (code_reg == `SFSP_OP_SERB_CODE) | (code_reg == `SFSP_OP_BERA_CODE));
  wire is_cera_w = end_ok_w & (byte_cnt_reg == 3'h0) &
                   ((code_reg == `SFSP_OP_CERA_CODE) | (code_reg == `SFSP_OP_CERB_CODE));

  // region check on the lower two protect bits only
  sfsp_guard_if guard ();
  assign guard.bp_low = bp_reg[1:0];
  assign guard.addr   = addr_sh_reg[17:0];
  sfsp_region_check #(.SIZE(SIZE)) u_region (.g(guard));

  wire free_w     = wel_reg & !busy_reg;
  wire sr_lock_w  = swd_reg & !wp_hi_w;
  wire wrst_ok_w  = is_wrst_w & free_w & !sr_lock_w;
  wire prog_ok_w  = is_prog_w & free_w & !guard.hit;
  wire era_ok_w   = is_era_w & free_w & !guard.hit;
  wire cera_ok_w  = is_cera_w & free_w & (bp_reg == 3'h0);
  wire arr_done_w = arr_d_reg & !array_busy;
  wire wrst_done_w = wrst_busy_reg & (wrst_cnt_reg == '0);

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wel_reg       <= 1'b0;
      bp_reg        <= 3'h0;
      swd_reg       <= 1'b0;
      busy_reg      <= 1'b0;
      wrst_busy_reg <= 1'b0;
      wrst_cnt_reg  <= '0;
      arr_d_reg     <= 1'b0;
      arr_pend_reg  <= 1'b0;
    end else begin
      arr_d_reg <= array_busy;
      if (prog_ok_w | era_ok_w | cera_ok_w) arr_pend_reg <= 1'b1;
      else if (arr_done_w) arr_pend_reg <= 1'b0;
      // completion clears the latch; new enables are accepted while busy
      if (wrst_done_w | arr_done_w) wel_reg <= 1'b0;
      else if (is_write_disable_cmd_w) wel_reg <= 1'b0;
      else if (is_write_enable_cmd_w) wel_reg <= 1'b1;
      if (wrst_ok_w) begin
        bp_reg        <= data_reg[`SFSP_BIT_BP2:`SFSP_BIT_BP0];
        swd_reg       <= data_reg[`SFSP_BIT_SWD];
        wrst_busy_reg <= 1'b1;
        wrst_cnt_reg  <= ($clog2(WRST_CYC+1))'(WRST_CYC - 1);
      end else if (wrst_busy_reg) begin
        if (wrst_cnt_reg == '0) wrst_busy_reg <= 1'b0;
        else wrst_cnt_reg <= wrst_cnt_reg - 1'b1;
      end
      busy_reg <= wrst_ok_w | (wrst_busy_reg & !wrst_done_w) | array_busy | (arr_pend_reg & !arr_done_w) |
                  prog_ok_w | era_ok_w | cera_ok_w;
    end
  end

  wire [7:0] status_w = {swd_reg, 2'b00, bp_reg, wel_reg, busy_reg};

  // read-back shifter: byte reloads every eight clocks of the frame
  logic [7:0] out_sh_reg;
  wire rd_sel_w = (state_reg == SFSP_TAIL) & (code_reg == `SFSP_OP_RDST_CODE);
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      out_sh_reg       <= 8'h00;
      spi_so           <= 1'b0;
      spi_so_oe_n      <= 1'b1;
      prog_start       <= 1'b0;
      erase_start      <= 1'b0;
      full_erase_start <= 1'b0;
      op_code          <= 8'h00;
      op_addr          <= '0;
      status_byte      <= `SFSP_STATUS_RESET;
    end else begin
      status_byte      <= status_w;
      prog_start       <= prog_ok_w;
      erase_start      <= era_ok_w;
      full_erase_start <= cera_ok_w;
      if (prog_ok_w | era_ok_w | cera_ok_w) begin
        op_code <= code_reg;
        op_addr <= addr_sh_reg[17:0];
      end
      spi_so_oe_n <= !rd_sel_w;
      if (!rd_sel_w) out_sh_reg <= status_w;
      else if (fall_w) begin
        if (bit_cnt_reg == 3'h0) begin
          spi_so     <= status_w[7];
          out_sh_reg <= {status_w[6:0], 1'b0};
        end else begin
          spi_so     <= out_sh_reg[7];
          out_sh_reg <= {out_sh_reg[6:0], 1'b0};
        end
      end
    end
  end

  initial begin
    if (WRST_CYC < 1) $error("status write time too short");
  end
endmodule // sfsp_status_protect

// ===== test/sfsp_sp_monitor.sv
// assertion checker for the status and protection block
`timescale 1ns/100ps
module sfsp_sp_monitor #(
  parameter logic [1:0] SIZE = 2'h2
) (
  // clock and reset
  input wire logic                 mclk,
  input wire logic                 sys_rst,
  // pins, engine and status view
  input wire logic                 wp_n,
  input wire logic                 prog_start,
  input wire logic                 erase_start,
  input wire logic                 full_erase_start,
  input wire sfsp_pkg::sfsp_addr_t op_addr,
  input wire logic                 array_busy,
  input wire logic [7:0]           status_byte
);
  import sfsp_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  wire [17:0] half_a = (SIZE == 2'h2 ? 18'h1FFFF : 18'h0FFFF) + 18'h00001;
  wire [17:0] qtr_a  = half_a + {1'b0, half_a[17:1]};
  wire [1:0]  bp_lo  = status_byte[3:2];
  // bp2 deliberately left out of the region
  wire        in_reg = bp_lo == 2'h3 || (SIZE != 2'h0 &&
                       ((bp_lo == 2'h2 && op_addr >= half_a) || (bp_lo == 2'h1 && op_addr >= qtr_a)));
  sequence busy_held;
    array_busy [*3];
  endsequence
  sequence frozen;
    (status_byte[7] && !wp_n) [*4];
  endsequence
  busy_flag_a: assert property (busy_held |-> status_byte[0])
    else $error("busy flag low while engine busy");
  latch_gate_a: assert property ((prog_start || erase_start || full_erase_start) |-> status_byte[1])
    else $error("operation started without latch");
  engine_done_a: assert property ($fell(array_busy) |-> ##[1:3] !status_byte[1])
    else $error("latch kept after engine done");
  status_done_a: assert property ($fell(status_byte[0]) |-> ##[0:2] !status_byte[1])
    else $error("latch kept after busy end");
  region_guard_a: assert property ((prog_start || erase_start) |-> !in_reg)
    else $error("write started inside protected region");
  full_erase_a: assert property (full_erase_start |-> status_byte[4:2] == 3'h0)
    else $error("full erase with protect bits set");
  status_frozen_a: assert property (frozen |=> $stable(status_byte[7:2]))
    else $error("protect bits changed while frozen");
  reset_value_a: assert property ($past(sys_rst) |-> status_byte == 8'h00)
    else $error("status not zero after reset");
  reserved_zero_a: assert property (status_byte[6:5] == 2'h0)
    else $error("reserved status bits set");
endmodule // sfsp_sp_monitor

// ===== test/sfsp_spi_host.sv
// serial host model framing instructions towards the block
`timescale 1ns/100ps
module sfsp_spi_host (
  // alignment clock
  input  wire logic mclk,
  // serial pins
  output logic      sck,
  output logic      cs_n,
  output logic      si,
  input  wire logic so,
  input  wire logic so_oe_n
);
  // a released line must not show the stale bit
  wire so_line = so_oe_n ? ~so : so;
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  // mode 0, msb first; clock stands still between frames
  task automatic xfer(input logic [39:0] d, input int nb, output logic [7:0] rd);
    rd = 8'h00;
    @(negedge mclk);
    cs_n = 1'b0;
    for (int i = 0; i < nb; i++) begin
      si = d[39 - i];
      #80;
      sck = 1'b1;
      rd = {rd[6:0], so_line};
      #80;
      sck = 1'b0;
    end
    #80;
    cs_n = 1'b1;
    #80;
  endtask
endmodule // sfsp_spi_host

// ===== test/testbench.sv
// self-checking bench of the status and protection block
`timescale 1ns/100ps
bind sfsp_status_protect sfsp_sp_monitor #(.SIZE(SIZE)) mon (.mclk(mclk), .sys_rst(sys_rst), .wp_n(wp_n),
  .prog_start(prog_start), .erase_start(erase_start), .full_erase_start(full_erase_start), .op_addr(op_addr),
  .array_busy(array_busy), .status_byte(status_byte));
module testbench;
  import sfsp_pkg::*;
  typedef struct { logic [2:0] bp; logic [17:0] addr; logic ok; } sfsp_row_s;
  sfsp_row_s  rows [7] = '{'{3'h0, 18'h3FFFF, 1'b1}, '{3'h1, 18'h2FFFF, 1'b1}, '{3'h1, 18'h30000, 1'b0},
    '{3'h2, 18'h1FFFF, 1'b1}, '{3'h2, 18'h20000, 1'b0}, '{3'h3, 18'h00000, 1'b0}, '{3'h4, 18'h3FFFF, 1'b1}};
  logic       mclk, sys_rst, wp_n, array_busy, sck, cs_n, si, so, so_oe_n;
  logic       ps, es, fs;
  logic [7:0] opc, sb, rd;
  sfsp_addr_t oa;
  int         fails, tests_run, n_prog, n_full, n_era, n0;
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    n_prog <= n_prog + ps;
    n_full <= n_full + fs;
    n_era  <= n_era + es;
  end
  sfsp_status_protect #(.SIZE(2'h2), .WRST_CYC(4)) uut (.mclk(mclk), .sys_rst(sys_rst), .spi_sck(sck),
    .spi_cs_n(cs_n), .spi_si(si), .wp_n(wp_n), .spi_so(so), .spi_so_oe_n(so_oe_n), .prog_start(ps),
    .erase_start(es), .full_erase_start(fs), .op_code(opc), .op_addr(oa), .array_busy(array_busy),
    .status_byte(sb));
  sfsp_spi_host host (.mclk(mclk), .sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe_n(so_oe_n));
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string what, input logic [17:0] seen, input logic [17:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic op(input logic [39:0] d, input int nb);
    host.xfer(d, nb, rd);
    repeat (8) @(negedge mclk);
  endtask
  // wait bounded, status write busy is short
  task automatic wrst(input logic [7:0] v);
    int i;
    op({8'h06, 32'h0}, 8);
    op({8'h01, v, 24'h0}, 16);
    for (i = 0; i < 300 && sb[0] !== 1'b0; i++) @(negedge mclk);
    if (i == 300) begin
      fails++;
      tally_and_finish;
    end
  endtask
  task automatic engine;
    array_busy = 1'b1;
    repeat (5) @(negedge mclk);
    chk("busy flag", sb[0], 1'b1);
    array_busy = 1'b0;
    repeat (5) @(negedge mclk);
    chk("latch after done", sb[1], 1'b0);
  endtask
  initial begin
    sys_rst = 1'b1;
    wp_n = 1'b1;
    array_busy = 1'b0;
    repeat (4) @(negedge mclk);
    sys_rst = 1'b0;
    repeat (4) @(negedge mclk);
    chk("status after reset", sb, 8'h00);
    foreach (rows[k]) begin
      wrst({3'h0, rows[k].bp, 2'h0});
      n0 = n_prog;
      op({8'h06, 32'h0}, 8);
      op({8'h02, 6'h00, rows[k].addr, 8'hA5}, 40);
      chk("program start", 18'(n_prog - n0), 18'(rows[k].ok));
      if (rows[k].ok) begin
        chk("program addr", oa, rows[k].addr);
        chk("program code", opc, 8'h02);
        engine;
      end
      $display("row %0d done", k);
    end
    op({8'h06, 32'h0}, 7);
    chk("partial enable", sb[1], 1'b0);
    op({8'h06, 32'h0}, 8);
    chk("enable", sb[1], 1'b1);
    op({8'h04, 32'h0}, 8);
    chk("disable", sb[1], 1'b0);
    n0 = n_prog;
    op({8'h02, 32'h0}, 40);
    chk("program no latch", 18'(n_prog - n0), 18'h0);
    $display("latch tests done");
    n0 = n_full;
    op({8'h06, 32'h0}, 8);
    op({8'hC7, 32'h0}, 8);
    chk("erase with bp2", 18'(n_full - n0), 18'h0);
    wrst(8'h00);
    op({8'h06, 32'h0}, 8);
    op({8'h60, 32'h0}, 8);
    chk("full erase", 18'(n_full - n0), 18'h1);
    engine;
    n0 = n_era;
    op({8'h06, 32'h0}, 8);
    op({8'hD8, 24'h030000, 8'h00}, 32);
    chk("block erase", 18'(n_era - n0), 18'h1);
    chk("erase code", opc, 8'hD8);
    chk("erase addr", oa, 18'h30000);
    engine;
    $display("erase tests done");
    wrst(8'hFC);
    chk("reserved bits", sb, 8'h9C);
    op({8'h05, 32'h0}, 16);
    chk("status read", rd, 8'h9C);
    wp_n = 1'b0;
    wrst(8'h00);
    chk("frozen", sb & 8'hFC, 8'h9C);
    wp_n = 1'b1;
    wrst(8'h00);
    chk("unfrozen", sb, 8'h00);
    $display("protect tests done");
    tally_and_finish;
  end
endmodule // testbench
